// ==== logic/sptx_ctrl.sv ====
/*
 transmit control/status and pin control registers of a buffered serial port,
 with sample-rate/frame-sync generator and a transmit shifter on the link clock.
 assumes a plain register port on clk_sys_in, link clock clk_link_in free of phase relation.
*/
// Function
// - reserved bits hold nothing and read zero
// - control bit 9 enables free-running mode
// - control bit 8 enables soft stop mode
// - frame-gen reset low holds frame logic, no generated frame sync
// - on frame-gen release, load counters; sync after frame_period+1 generator clocks
// - rate-gen reset low holds generator; high runs generator clock per config
// - two-bit irq mode selects ready, constant zero (mode 01, no block end), new frame, or sync error
// - sync error bit set on detection; software writing one also sets it
// - empty flag reads zero when shift and data registers are both empty, one when either holds data
// - ready bit reads one when data register can take a word
// - transmitter reset low keeps transmitter disabled and reset
// - gpio enable during transmitter reset hands frame and clock pin value and enable to software; data pin is driven low
`timescale 1ns/100ps
`include "sptx_cfg.svh"
module sptx_ctrl
    import sptx_pkg::*;
#(
    parameter int WORD_BITS = `SPTX_WORD_BITS
) (
    // clocks and reset
    input  wire logic                     clk_sys_in,
    input  wire logic                     clk_link_in,
    input  wire logic                     rst_n_in,
    // register port
    input  wire logic [`SPTX_ADDR_W-1:0]  addr_in,
    input  wire logic [15:0]              wdata_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    output logic      [15:0]              rdata_out,
    // serial pins
    output logic                          dx_out,
    output logic                          dx_oe_out,
    input  wire logic                     fsx_in,
    output logic                          fsx_out,
    output logic                          fsx_oe_out,
    input  wire logic                     clkx_in,
    output logic                          clkx_out,
    output logic                          clkx_oe_out,
    input  wire logic                     clks_in,
    input  wire logic                     dr_in,
    // event and mode outputs
    output logic                          tx_interrupt_out,
    output logic                          free_run_out,
    output logic                          soft_stop_out
);
    initial
    begin
        if (WORD_BITS < 2 || WORD_BITS > 16)
            $error("sptx_ctrl: WORD_BITS must be 2..16");
    end

    // reset release through two flops
    logic rst_a_r;
    logic rst_n;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_a_r <= 1'b0;
            rst_n   <= 1'b0;
        end
        else
        begin
            rst_a_r <= 1'b1;
            rst_n   <= rst_a_r;
        end
    end

    // register state
    sptx_word_t ctrl_r;
    sptx_word_t ctrl_nxt;
    sptx_word_t pin_r;
    sptx_word_t pin_nxt;
    sptx_word_t data_r;
    sptx_word_t data_nxt;
    sptx_word_t rate_r;
    sptx_word_t rate_nxt;
    sptx_word_t frame_r;
    sptx_word_t frame_nxt;
    logic       full_r;
    logic       full_nxt;
    logic       req_tgl_r;
    logic       req_tgl_nxt;
    sptx_word_t rdata_nxt;

    // link-side results seen in the system domain
    logic       ack_tgl_s;
    logic       busy_s;
    logic       err_tgl_s;
    logic       fs_tgl_s;
    logic       err_tgl_d_r;
    logic       fs_tgl_d_r;
    logic       ack_seen_r;
    logic [2:0] pins_s;
    logic       tx_reset_n_l;

    wire        wr_ctrl   = wr_in && addr_in == `SPTX_OFS_CTRL;
    wire        err_evt   = err_tgl_s ^ err_tgl_d_r;
    wire        fs_evt    = fs_tgl_s ^ fs_tgl_d_r;
    wire        ack_evt   = ack_tgl_s ^ ack_seen_r;
    wire        tx_reset_n_on   = ctrl_r[`SPTX_B_TX_RESET_N];
    wire        tx_ready  = tx_reset_n_on && !full_r;
    wire        empty_n   = busy_s || full_r;
    wire        gpio_mode = !tx_reset_n_on && pin_r[`SPTX_B_GPIO_EN];

    function automatic sptx_word_t merge(input sptx_word_t old, input sptx_word_t nw, input sptx_word_t msk);
        merge = (old & ~msk) | (nw & msk);
    endfunction

    always_comb
    begin
        ctrl_nxt    = ctrl_r;
        pin_nxt     = pin_r;
        data_nxt    = data_r;
        rate_nxt    = rate_r;
        frame_nxt   = frame_r;
        full_nxt    = full_r;
        req_tgl_nxt = req_tgl_r;
        if (wr_ctrl)
            ctrl_nxt = merge(ctrl_r, wdata_in, `SPTX_CTRL_WMASK);
        if (wr_ctrl && wdata_in[`SPTX_B_SYNCERR])
            ctrl_nxt[`SPTX_B_SYNCERR] = 1'b1;
        if (err_evt)
            ctrl_nxt[`SPTX_B_SYNCERR] = 1'b1;
        if (wr_in && addr_in == `SPTX_OFS_PIN)
            pin_nxt = merge(pin_r, wdata_in, `SPTX_PIN_WMASK);
        if (wr_in && addr_in == `SPTX_OFS_RATE)
            rate_nxt = wdata_in;
        if (wr_in && addr_in == `SPTX_OFS_FRAME)
            frame_nxt = wdata_in;
        if (ack_evt)
            full_nxt = 1'b0;
        if (full_r && !ack_evt && req_tgl_r == ack_seen_r)
            req_tgl_nxt = ~req_tgl_r;
        if (wr_in && addr_in == `SPTX_OFS_DATA && tx_reset_n_on)
        begin
            data_nxt = wdata_in;
            full_nxt = 1'b1;
        end
        if (!tx_reset_n_on)
            full_nxt = 1'b0;
        rdata_nxt = '0;
        case (addr_in)
            `SPTX_OFS_CTRL:
            begin
                rdata_nxt = ctrl_r & 16'h03f9;
                rdata_nxt[`SPTX_B_EMPTY_N] = empty_n;
                rdata_nxt[`SPTX_B_RDY]     = tx_ready;
            end
            `SPTX_OFS_PIN:
            begin
                rdata_nxt = pin_r & `SPTX_PIN_WMASK;
                rdata_nxt[`SPTX_B_CLKS_ST] = pins_s[2];
                rdata_nxt[`SPTX_B_DX_ST]   = pins_s[1];
                rdata_nxt[`SPTX_B_DR_ST]   = pins_s[0];
            end
            `SPTX_OFS_DATA:  rdata_nxt = data_r;
            `SPTX_OFS_RATE:  rdata_nxt = rate_r;
            `SPTX_OFS_FRAME: rdata_nxt = frame_r;
            default:         rdata_nxt = '0;
        endcase
        if (!rd_in)
            rdata_nxt = '0;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r      <= `SPTX_CTRL_RST;
            pin_r       <= `SPTX_PIN_RST;
            data_r      <= '0;
            rate_r      <= `SPTX_RATE_RST;
            frame_r     <= `SPTX_FRAME_RST;
            full_r      <= 1'b0;
            req_tgl_r   <= 1'b0;
            err_tgl_d_r <= 1'b0;
            fs_tgl_d_r  <= 1'b0;
            ack_seen_r  <= 1'b0;
            rdata_out   <= '0;
        end
        else
        begin
            ctrl_r      <= ctrl_nxt;
            pin_r       <= pin_nxt;
            data_r      <= data_nxt;
            rate_r      <= rate_nxt;
            frame_r     <= frame_nxt;
            full_r      <= full_nxt;
            req_tgl_r   <= req_tgl_nxt;
            err_tgl_d_r <= err_tgl_s;
            fs_tgl_d_r  <= fs_tgl_s;
            ack_seen_r  <= ack_tgl_s;
            rdata_out   <= rdata_nxt;
        end
    end

    // interrupt source mux
    always_comb
    begin
        case (ctrl_r[`SPTX_B_IRQM_HI:`SPTX_B_IRQM_LO])
            2'b00:   tx_interrupt_out = tx_ready;
            2'b01:   tx_interrupt_out = fs_evt && ctrl_r[`SPTX_B_FREE] == 1'b0 && 1'b0;
            2'b10:   tx_interrupt_out = fs_evt;
            2'b11:   tx_interrupt_out = ctrl_r[`SPTX_B_SYNCERR];
            default: tx_interrupt_out = 1'b0;
        endcase
    end
    assign free_run_out  = ctrl_r[`SPTX_B_FREE];
    assign soft_stop_out = ctrl_r[`SPTX_B_SOFT];

    // link domain: controls cross as levels; data word is stable while request toggle is pending
    logic [3:0] ctl_l;
    logic       req_l;
    logic       ext_fs_l;
    sptx_sync #(.WIDTH(5)) u_to_link (
        .clk_in   (clk_link_in),
        .rst_n_in (rst_n),
        .d_in     ({ctrl_r[`SPTX_B_FRAME_GEN_RESET_N], ctrl_r[`SPTX_B_RATE_GEN_RESET_N], tx_reset_n_on, pin_r[`SPTX_B_FSX_SRC], req_tgl_r}),
        .q_out    ({ctl_l, req_l})
    );
    sptx_sync #(.WIDTH(1)) u_fs_in (
        .clk_in   (clk_link_in),
        .rst_n_in (rst_n),
        .d_in     (fsx_in ^ pin_r[`SPTX_B_FSX_POL]),
        .q_out    (ext_fs_l)
    );

    sptx_state_t st_r;
    sptx_state_t st_nxt;
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic [15:0] per_r;
    logic [15:0] per_nxt;
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;
    logic        generator_clock_r;
    logic        generator_clock_nxt;
    logic        fsg_r;
    logic        fsg_nxt;
    logic        ack_l_r;
    logic        ack_l_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic        err_l_r;
    logic        err_l_nxt;
    logic        fst_l_r;
    logic        fst_l_nxt;
    logic        dx_r;
    logic        dx_nxt;
    logic        ext_fs_d_r;

    wire frame_gen_reset_n_l  = ctl_l[3];
    wire rate_gen_reset_n_l  = ctl_l[2];
    assign tx_reset_n_l = ctl_l[1];
    wire fs_int  = ctl_l[0];
    wire tick    = rate_gen_reset_n_l && div_r == 16'h0000;
    // data moves on the rising generator clock so the far side samples it mid-bit
    wire bit_edge = tick && !generator_clock_r;
    wire fs_now  = fs_int ? fsg_r : (ext_fs_l && !ext_fs_d_r);

    always_comb
    begin
        div_nxt  = div_r;
        generator_clock_nxt = generator_clock_r;
        per_nxt  = per_r;
        fsg_nxt  = 1'b0;
        if (!rate_gen_reset_n_l)
        begin
            div_nxt  = rate_r;
            generator_clock_nxt = 1'b0;
        end
        else if (tick)
        begin
            div_nxt  = rate_r;
            generator_clock_nxt = ~generator_clock_r;
        end
        else
            div_nxt = div_r - 16'h0001;
        if (!frame_gen_reset_n_l || !rate_gen_reset_n_l)
            per_nxt = frame_r;
        else if (tick && generator_clock_r)
        begin
            if (per_r == 16'h0000)
            begin
                fsg_nxt = 1'b1;
                per_nxt = frame_r;
            end
            else
                per_nxt = per_r - 16'h0001;
        end
        st_nxt    = st_r;
        sh_nxt    = sh_r;
        cnt_nxt   = cnt_r;
        ack_l_nxt = ack_l_r;
        busy_nxt  = busy_r;
        err_l_nxt = err_l_r;
        fst_l_nxt = fs_now ? ~fst_l_r : fst_l_r;
        dx_nxt    = dx_r;
        case (st_r)
            SPTX_IDLE:
            begin
                // busy holds a loaded word until its frame comes
                if (req_l != ack_l_r)
                begin
                    sh_nxt    = data_r;
                    ack_l_nxt = req_l;
                    busy_nxt  = 1'b1;
                end
                if (fs_now && (busy_r || req_l != ack_l_r))
                begin
                    st_nxt  = SPTX_SHIFT;
                    dx_nxt  = sh_nxt[WORD_BITS-1];
                    sh_nxt  = sh_nxt << 1;
                    cnt_nxt = 5'(WORD_BITS - 1);
                end
            end
            SPTX_SHIFT:
            begin
                if (fs_now)
                    err_l_nxt = ~err_l_r;
                if (bit_edge && cnt_r == 5'd0)
                begin
                    st_nxt   = SPTX_IDLE;
                    busy_nxt = 1'b0;
                end
                else if (bit_edge)
                begin
                    dx_nxt  = sh_r[WORD_BITS-1];
                    sh_nxt  = sh_r << 1;
                    cnt_nxt = cnt_r - 5'd1;
                end
            end
            SPTX_GPIO:  st_nxt = SPTX_IDLE;
            default:    st_nxt = SPTX_IDLE;
        endcase
        if (!tx_reset_n_l)
        begin
            st_nxt   = SPTX_IDLE;
            busy_nxt = 1'b0;
            dx_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clk_link_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= SPTX_IDLE;
            div_r <= '0;
            per_r <= '0;
            sh_r <= '0;
            cnt_r <= '0;
            generator_clock_r <= 1'b0;
            fsg_r <= 1'b0;
            ack_l_r <= 1'b0;
            busy_r <= 1'b0;
            err_l_r <= 1'b0;
            fst_l_r <= 1'b0;
            dx_r <= 1'b0;
            ext_fs_d_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            per_r <= per_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            generator_clock_r <= generator_clock_nxt;
            fsg_r <= fsg_nxt;
            ack_l_r <= ack_l_nxt;
            busy_r <= busy_nxt;
            err_l_r <= err_l_nxt;
            fst_l_r <= fst_l_nxt;
            dx_r <= dx_nxt;
            ext_fs_d_r <= ext_fs_l;
        end
    end

    // link to system crossings: toggles for events, level for busy
    sptx_sync #(.WIDTH(4)) u_to_sys (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_n),
        .d_in     ({ack_l_r, busy_r, err_l_r, fst_l_r}),
        .q_out    ({ack_tgl_s, busy_s, err_tgl_s, fs_tgl_s})
    );
    sptx_sync #(.WIDTH(3)) u_pins (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_n),
        .d_in     ({clks_in, dx_r, dr_in}),
        .q_out    (pins_s)
    );

    // pin drive; gpio mode hands frame and clock pin value and enable to software, data pin is driven low
    always_comb
    begin
        if (gpio_mode)
        begin
            dx_out      = pin_r[`SPTX_B_DX_ST];
            fsx_out     = pin_r[`SPTX_B_FSX_POL];
            fsx_oe_out  = pin_r[`SPTX_B_FSX_SRC];
            clkx_out    = pin_r[`SPTX_B_CLKX_POL];
            clkx_oe_out = pin_r[`SPTX_B_CLKX_SRC];
        end
        else
        begin
            dx_out      = dx_r;
            fsx_out     = fsg_r ^ pin_r[`SPTX_B_FSX_POL];
            fsx_oe_out  = pin_r[`SPTX_B_FSX_SRC];
            clkx_out    = generator_clock_r ^ pin_r[`SPTX_B_CLKX_POL];
            clkx_oe_out = pin_r[`SPTX_B_CLKX_SRC];
        end
        dx_oe_out = 1'b1;
    end

    // checks
    a_rsvd_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        $past(rd_in) && $past(addr_in) == `SPTX_OFS_CTRL |-> rdata_out[15:10] == 6'h00)
        else $error("reserved control bits read nonzero");
    a_free_bit: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        wr_ctrl |=> free_run_out == $past(wdata_in[`SPTX_B_FREE]))
        else $error("free-run bit not taken");
    a_soft_bit: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        wr_ctrl |=> soft_stop_out == $past(wdata_in[`SPTX_B_SOFT]))
        else $error("soft bit not taken");
    a_fsg_held: assert property (@(posedge clk_link_in) disable iff (!rst_n)
        !frame_gen_reset_n_l |=> !fsg_r)
        else $error("frame sync while generator in reset");
    a_per_load: assert property (@(posedge clk_link_in) disable iff (!rst_n)
        !frame_gen_reset_n_l |=> per_r == $past(frame_r))
        else $error("frame counter not loaded");
    a_rate_hold: assert property (@(posedge clk_link_in) disable iff (!rst_n)
        !rate_gen_reset_n_l [*2] |-> !generator_clock_r)
        else $error("generator clock runs in reset");
    a_err_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        wr_ctrl && wdata_in[`SPTX_B_SYNCERR] |=> ctrl_r[`SPTX_B_SYNCERR])
        else $error("sync error not forced by write");
    a_ready_rd: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        rd_in && addr_in == `SPTX_OFS_CTRL |=> rdata_out[`SPTX_B_RDY] == $past(tx_ready))
        else $error("ready bit wrong");
    a_tx_reset_n_idle: assert property (@(posedge clk_link_in) disable iff (!rst_n)
        !tx_reset_n_l |=> st_r == SPTX_IDLE)
        else $error("transmitter active in reset");
    a_ro_ignored: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        1'b1 |-> ctrl_r[`SPTX_B_EMPTY_N] == 1'b0 && ctrl_r[`SPTX_B_RDY] == 1'b0)
        else $error("read-only bit stored");
endmodule

// ==== logic/sptx_cfg.svh ====
/*
 constants for the serial transmit control block: offsets, field positions, reset values, word width.
 assumes it is included by bare name from design files.
*/
`ifndef SPTX_CFG_SVH
`define SPTX_CFG_SVH
`define SPTX_ADDR_W          4
`define SPTX_OFS_CTRL        4'h0
`define SPTX_OFS_PIN         4'h1
`define SPTX_OFS_DATA        4'h2
`define SPTX_OFS_RATE        4'h3
`define SPTX_OFS_FRAME       4'h4
`define SPTX_CTRL_RST        16'h0000
`define SPTX_PIN_RST         16'h0000
`define SPTX_RATE_RST        16'h0001
`define SPTX_FRAME_RST       16'h000f
`define SPTX_CTRL_WMASK      16'h03f9
`define SPTX_PIN_WMASK       16'h3f0f
`define SPTX_B_FREE          9
`define SPTX_B_SOFT          8
`define SPTX_B_FRAME_GEN_RESET_N          7
`define SPTX_B_RATE_GEN_RESET_N          6
`define SPTX_B_IRQM_HI       5
`define SPTX_B_IRQM_LO       4
`define SPTX_B_SYNCERR       3
`define SPTX_B_EMPTY_N       2
`define SPTX_B_RDY           1
`define SPTX_B_TX_RESET_N          0
`define SPTX_B_GPIO_EN       13
`define SPTX_B_FSX_SRC       11
`define SPTX_B_CLKX_SRC      9
`define SPTX_B_CLKS_ST       6
`define SPTX_B_DX_ST         5
`define SPTX_B_DR_ST         4
`define SPTX_B_FSX_POL       3
`define SPTX_B_CLKX_POL      1
`define SPTX_WORD_BITS       16
`endif

// ==== logic/sptx_pkg.sv ====
/*
 types of the serial transmit control block.
 assumes sptx_cfg.svh constants beside it.
*/
package sptx_pkg;
    typedef enum logic [2:0]
    {
        SPTX_IDLE  = 3'b001,
        SPTX_SHIFT = 3'b010,
        SPTX_GPIO  = 3'b100
    } sptx_state_t;
    typedef logic [15:0] sptx_word_t;
endpackage

// ==== logic/sptx_sync.sv ====
/*
 two-flop level synchroniser, parameterised width.
 assumes destination clock and active-low async reset.
*/
`timescale 1ns/100ps
module sptx_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // data
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    initial
    begin
        if (WIDTH < 1)
            $error("sptx_sync: WIDTH must be at least 1");
    end

    always_comb
    begin
        meta_nxt = d_in;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_out  <= q_nxt;
        end
    end
endmodule

// ==== verification/sptx_partner.sv ====
/*
 far-side framed serial receiver model for the transmit control block.
 assumes frame and clock wires resolved by the bench; it never drives them itself.
*/
`timescale 1ns/100ps
module sptx_partner (
    // link wires
    input  wire logic        listen_in,
    input  wire logic        fsx_in,
    input  wire logic        clkx_in,
    input  wire logic        dx_in,
    // own drive, released so it stands still
    output logic             fsx_drv_out,
    output logic             clkx_drv_out,
    // captured word
    output logic [15:0]      word_out,
    output logic             got_out
);
    int          cnt;
    logic        act;
    logic [15:0] sh;
    initial
    begin
        fsx_drv_out  = 1'b0;
        clkx_drv_out = 1'b0;
        word_out     = 16'h0000;
        got_out      = 1'b0;
        cnt          = 0;
        act          = 1'b0;
        sh           = 16'h0000;
    end
    // look just after each falling edge: frame and data launch on clock edges too
    always @(negedge clkx_in)
    begin
        #1;
        if (act)
        begin
            sh = {sh[14:0], dx_in};
            cnt++;
            if (cnt == 16)
            begin
                act      = 1'b0;
                word_out = sh;
                got_out  = 1'b1;
            end
        end
        else if (listen_in && !got_out && fsx_in === 1'b1)
        begin
            act = 1'b1;
            cnt = 0;
        end
    end
endmodule

// ==== verification/testbench.sv ====
/*
 self-checking bench for the transmit control block: register tasks, pin modes, generator timing, one word out.
 assumes the partner model beside it and the design's constant header.
*/
`timescale 1ns/100ps
`include "sptx_cfg.svh"
module testbench;
    import sptx_pkg::*;
    logic        clk_sys, clk_link, rst_n, wr_en, rd_en, clks, dr, listen;
    logic [3:0]  addr;
    sptx_word_t  wdata, rdata, q;
    logic        dx, dx_oe, fsx, fsx_oe, clkx, clkx_oe, irq, free_run, soft_stop;
    logic        fsx_drv, clkx_drv, got;
    logic [15:0] word;
    wire         fsx_w  = fsx_oe ? fsx : fsx_drv;
    wire         clkx_w = clkx_oe ? clkx : clkx_drv;
    int          fails, cmp_count, n;
    logic        seen;

    sptx_ctrl dut_u (.clk_sys_in(clk_sys), .clk_link_in(clk_link), .rst_n_in(rst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_en), .rd_in(rd_en), .rdata_out(rdata), .dx_out(dx), .dx_oe_out(dx_oe),
        .fsx_in(fsx_w), .fsx_out(fsx), .fsx_oe_out(fsx_oe), .clkx_in(clkx_w), .clkx_out(clkx),
        .clkx_oe_out(clkx_oe), .clks_in(clks), .dr_in(dr), .tx_interrupt_out(irq),
        .free_run_out(free_run), .soft_stop_out(soft_stop));
    sptx_partner far_u (.listen_in(listen), .fsx_in(fsx_w), .clkx_in(clkx_w), .dx_in(dx),
        .fsx_drv_out(fsx_drv), .clkx_drv_out(clkx_drv), .word_out(word), .got_out(got));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // odd offset keeps the link clock out of phase with the system clock
    initial
    begin
        clk_link = 1'b0;
        #13;
        forever #32 clk_link = ~clk_link;
    end

    task automatic reg_wr(input logic [3:0] a, input sptx_word_t d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output sptx_word_t d);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input sptx_word_t got_v, input sptx_word_t exp_v);
        cmp_count++;
        if (got_v !== exp_v)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    // cycles until the event output next rises; capped so a silent design fails
    task automatic rise_wait(output int k);
        k = 0;
        while (irq === 1'b1 && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
        while (irq !== 1'b1 && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
    endtask
    task automatic highs(output int k);
        k = 0;
        repeat (300)
        begin
            @(posedge clk_sys);
            if (irq !== 1'b0)
                k++;
        end
    endtask
    task automatic wrap_up;
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        fails++;
        wrap_up;
    end

    initial
    begin
        {rst_n, wr_en, rd_en, clks, dr, listen} = 6'h00;
        addr  = 4'h0;
        wdata = 16'h0000;
        fails = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reg_rd(`SPTX_OFS_CTRL, q);
        chk(q, `SPTX_CTRL_RST);
        reg_rd(`SPTX_OFS_PIN, q);
        chk(q & 16'hff8f, `SPTX_PIN_RST);
        reg_wr(`SPTX_OFS_CTRL, 16'hfffe);
        reg_rd(`SPTX_OFS_CTRL, q);
        chk(q, 16'h03f8);
        chk({14'h0000, free_run, soft_stop}, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        reg_wr(`SPTX_OFS_CTRL, 16'h0030);
        reg_rd(`SPTX_OFS_CTRL, q);
        chk(q, 16'h0030);
        chk({13'h0000, free_run, soft_stop, irq}, 16'h0000);
        reg_wr(4'hf, 16'hffff);
        reg_rd(4'hf, q);
        chk(q, 16'h0000);
        clks <= 1'b1;
        dr   <= 1'b1;
        reg_wr(`SPTX_OFS_CTRL, 16'h0000);
        reg_wr(`SPTX_OFS_PIN, 16'hffff);
        repeat (4) @(posedge clk_sys);
        reg_rd(`SPTX_OFS_PIN, q);
        chk(q & 16'hffdf, 16'h3f5f);
        chk({12'h000, fsx_oe, fsx, clkx_oe, clkx}, 16'h000f);
        reg_wr(`SPTX_OFS_PIN, 16'h2a00);
        #1;
        chk({12'h000, fsx_oe, fsx, clkx_oe, clkx}, 16'h000a);
        reg_wr(`SPTX_OFS_PIN, 16'h0a00);
        reg_wr(`SPTX_OFS_RATE, 16'h0000);
        reg_wr(`SPTX_OFS_FRAME, 16'h0003);
        reg_wr(`SPTX_OFS_CTRL, 16'h0060);
        highs(n);
        chk(16'(n), 16'h0000);
        // generator clock 2 x 64 ns = 32 cycles, so 4 of them give 128
        reg_wr(`SPTX_OFS_CTRL, 16'h00e0);
        // first one also carries the crossings into and out of the link domain
        rise_wait(n);
        chk(16'(n >= 128 && n <= 200), 16'h0001);
        rise_wait(n);
        chk(16'(n >= 122 && n <= 134), 16'h0001);
        reg_wr(`SPTX_OFS_CTRL, 16'h00a0);
        highs(n);
        chk(16'(n), 16'h0000);
        reg_wr(`SPTX_OFS_FRAME, 16'h001f);
        reg_wr(`SPTX_OFS_CTRL, 16'h00c1);
        listen <= 1'b1;
        reg_wr(`SPTX_OFS_DATA, 16'ha5c3);
        seen = 1'b0;
        repeat (400)
        begin
            reg_rd(`SPTX_OFS_CTRL, q);
            if (q[`SPTX_B_EMPTY_N] === 1'b1)
                seen = 1'b1;
        end
        chk({15'h0000, seen}, 16'h0001);
        n = 0;
        while (got !== 1'b1 && n < 20000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(word, 16'ha5c3);
        repeat (100) @(posedge clk_sys);
        reg_rd(`SPTX_OFS_CTRL, q);
        chk(q, 16'h00c3);
        chk({15'h0000, irq}, 16'h0001);
        wrap_up;
    end
endmodule
